/* File: core/spi_eeprom_defines.svh */
// named constants for the serial eeprom status and protection block
`ifndef SPI_EEPROM_DEFINES_SVH
`define SPI_EEPROM_DEFINES_SVH
`define OPC_MASK 8'hf7
`define OPC_SET_LATCH 8'h06
`define OPC_CLR_LATCH 8'h04
`define OPC_RD_STATUS 8'h05
`define OPC_WR_STATUS 8'h01
`define OPC_WR_ARRAY 8'h02
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_PL_LO 2
`define ST_PL_HI 3
`define ST_DC_LO 4
`define ST_DC_HI 6
`define ST_ARM 7
`define ST_ALL_ONES 8'hff
`define ST_RESET 8'h00
`define DC_ZERO 3'h0
`define PROT_Q_BASE 10'h300
`define PROT_H_BASE 10'h200
`define BYTES_OPC 3'h1
`define BYTES_WRITE_STATUS_CMD 3'h2
`define BYTES_WARR_MIN 3'h4
`define BYTE_LAST_BIT 3'h7
`define BYTE_CNT_MAX 3'h7
`define WRITE_TIME_NS 4000000
`define SYS_CLK_NS 8
`define WRITE_CYCLES (`WRITE_TIME_NS / `SYS_CLK_NS)
`endif

/* File: core/spi_eeprom_pkg.sv */
// types for the serial eeprom status and protection block
package spi_eeprom_pkg;
  typedef enum logic [0:0] {
    WC_IDLE = 1'b0,
    WC_BUSY = 1'b1
  } wc_state_t;
  typedef enum logic [1:0] {
    PL_NONE = 2'b00,
    PL_QUARTER = 2'b01,
    PL_HALF = 2'b10,
    PL_ALL = 2'b11
  } prot_level_t;
endpackage

/* File: core/spi_eeprom_status_protect.sv */
// spi slave framing, status register and write protection of an eeprom
// What this block does
// - chip select rising ends the transfer and starts any pending write
// - after chip select rises, idle unless writing; output released
// - modes 0 and 3: sample input on rising, shift output on falling
// - pause low freezes the sequence and releases output; resumes later
// - pause tied high never suspends anything
// - status write refused under hardware guard or clear latch
// - status bit 0 is busy; while busy only status reads are served
// - bits 2 and 3 pick the protected region, reset to zero
// - bits 4 to 6 keep nothing and read zero when idle
// - guard active when guard pin low and arm bit set
// - arm bit cannot drop from 1 to 0 while guard pin low
// - hardware guard never blocks array writes
// - during an internal write every status bit reads 1
// - levels protect none, 300h-3ffh, 200h-3ffh or all
// - protected range never written; rest needs latch set
// - opcodes decoded with bit 3 ignored
// - latch clears after clear-latch, status write or array write
// - all bits travel most significant first
`timescale 1ns/1ns
`include "spi_eeprom_defines.svh"
module spi_eeprom_status_protect #(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic [7:0] status_o,
  output logic array_wr_go_o,
  output logic [9:0] array_wr_addr_o
);
  localparam int TW = $clog2(WRITE_CYCLES);

  // link side, clocked by the serial clock
  logic started_reg;
  logic frame_tgl_reg;
  logic [2:0] bit_reg;
  logic [2:0] byte_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;
  logic [7:0] data_reg;
  logic [1:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] stat_s1_reg;
  logic [7:0] stat_s2_reg;
  logic [7:0] stat_cap_reg;
  logic so_reg;
  logic so_oe_n_reg;
  // core side
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_seen_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  spi_eeprom_pkg::wc_state_t wc_state_reg;
  spi_eeprom_pkg::wc_state_t wc_state_next;
  logic [TW-1:0] wc_cnt_reg;
  logic [TW-1:0] wc_cnt_next;
  logic latch_reg;
  logic latch_next;
  logic arm_reg;
  logic [1:0] pl_reg;
  logic pend_st_reg;
  logic pend_arm_reg;
  logic [1:0] pend_pl_reg;
  logic [7:0] stat_view_reg;
  logic wr_go_reg;
  logic [9:0] wr_addr_reg;

  // frame state is cleared by chip select itself, as the clock may stop
  wire frame_clr = cs_n_i | rst_i;
  // pause or deselect releases the output at once, no clock needed
  wire so_off = cs_n_i | ~hold_n_i | rst_i;
  wire first_edge = ~started_reg;
  wire [2:0] bit_now = first_edge ? 3'h0 : bit_reg;
  wire [2:0] byte_now = first_edge ? 3'h0 : byte_reg;
  wire byte_end = bit_now == `BYTE_LAST_BIT;
  wire [7:0] shift_next = {shift_reg[6:0], si_i};
  wire byte_sat = byte_now == `BYTE_CNT_MAX;
  wire [2:0] byte_next = (byte_end & ~byte_sat) ? byte_now + 3'h1 : byte_now;
  wire [7:0] op_m = op_reg & `OPC_MASK;
  wire rd_phase = started_reg & (byte_reg != 3'h0)
    & (op_m == `OPC_RD_STATUS);

  always_ff @(posedge sck_i or posedge frame_clr)
  begin
    if (frame_clr)
      started_reg <= 1'b0;
    else if (hold_n_i)
      started_reg <= 1'b1;
  end

  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_tgl_reg <= 1'b0;
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      shift_reg <= 8'h00;
      op_reg <= 8'h00;
      data_reg <= 8'h00;
      addr_hi_reg <= 2'h0;
      addr_lo_reg <= 8'h00;
      stat_cap_reg <= `ST_RESET;
    end
    else if (hold_n_i && !cs_n_i)
    begin
      bit_reg <= bit_now + 3'h1;
      byte_reg <= byte_next;
      shift_reg <= shift_next;
      if (first_edge)
        frame_tgl_reg <= ~frame_tgl_reg;
      if (byte_end && byte_now == 3'h0)
        op_reg <= shift_next;
      if (byte_end && byte_now == 3'h1)
      begin
        data_reg <= shift_next;
        addr_hi_reg <= shift_next[1:0];
      end
      if (byte_end && byte_now == 3'h2)
        addr_lo_reg <= shift_next;
      // whole bytes only, so a status byte never changes while it shifts out
      if (byte_end)
        stat_cap_reg <= stat_s2_reg;
    end
  end

  // status word passes as quasi-static bits; a read racing the end
  // of a write may show a torn value, which the master rereads
  always_ff @(posedge sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat_s1_reg <= `ST_RESET;
      stat_s2_reg <= `ST_RESET;
    end
    else
    begin
      stat_s1_reg <= stat_view_reg;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  always_ff @(negedge sck_i or posedge rst_i)
  begin
    if (rst_i)
      so_reg <= 1'b0;
    else if (hold_n_i && !cs_n_i)
      so_reg <= stat_cap_reg[`BYTE_LAST_BIT - bit_reg];
  end

  always_ff @(negedge sck_i or posedge so_off)
  begin
    if (so_off)
      so_oe_n_reg <= 1'b1;
    else
      so_oe_n_reg <= ~rd_phase;
  end

  assign so_o = so_reg;
  assign so_oe_n_o = so_oe_n_reg;

  // core side decode of a finished frame
  wire busy = wc_state_reg == spi_eeprom_pkg::WC_BUSY;
  wire frame_end = cs_s2_reg & ~cs_s3_reg & (tgl_s2_reg != tgl_seen_reg);
  wire take = frame_end & ~busy;
  wire aligned = bit_reg == 3'h0;
  wire is_set = aligned & (byte_reg == `BYTES_OPC)
    & (op_m == `OPC_SET_LATCH);
  wire is_clr = aligned & (byte_reg == `BYTES_OPC)
    & (op_m == `OPC_CLR_LATCH);
  wire is_rd = byte_reg != 3'h0 & (op_m == `OPC_RD_STATUS);
  wire is_write_status_cmd = aligned & (byte_reg == `BYTES_WRITE_STATUS_CMD)
    & (op_m == `OPC_WR_STATUS);
  wire is_warr = aligned & (byte_reg >= `BYTES_WARR_MIN)
    & (op_m == `OPC_WR_ARRAY);
  wire hw_prot = ~wp_s2_reg & arm_reg;
  wire [9:0] addr = {addr_hi_reg, addr_lo_reg};
  wire prot_hit = (pl_reg == spi_eeprom_pkg::PL_ALL)
    | ((pl_reg == spi_eeprom_pkg::PL_HALF) & (addr >= `PROT_H_BASE))
    | ((pl_reg == spi_eeprom_pkg::PL_QUARTER) & (addr >= `PROT_Q_BASE));
  // guard gates the status write only, never the array
  wire go_write_status_cmd = take & is_write_status_cmd & latch_reg & ~hw_prot;
  wire go_warr = take & is_warr & latch_reg & ~prot_hit;
  wire wc_end = busy & (wc_cnt_reg == '0);
  wire latch_drop = wc_end
    | (take & (is_clr | (is_write_status_cmd & ~go_write_status_cmd) | (is_warr & ~go_warr)));
  wire [7:0] stat_word = {arm_reg, `DC_ZERO, pl_reg, latch_reg, 1'b0};

  assign latch_next = latch_drop ? 1'b0
    : (take & is_set) ? 1'b1 : latch_reg;
  assign wc_state_next = (go_write_status_cmd | go_warr) ? spi_eeprom_pkg::WC_BUSY
    : wc_end ? spi_eeprom_pkg::WC_IDLE : wc_state_reg;
  assign wc_cnt_next = (go_write_status_cmd | go_warr) ? TW'(WRITE_CYCLES - 1)
    : busy ? wc_cnt_reg - 1'b1 : wc_cnt_reg;

  always_ff @(posedge sys_clk_i)
  begin
    cs_s1_reg <= cs_n_i;
    cs_s2_reg <= cs_s1_reg;
    tgl_s1_reg <= frame_tgl_reg;
    tgl_s2_reg <= tgl_s1_reg;
    wp_s1_reg <= wp_n_i;
    wp_s2_reg <= wp_s1_reg;
    if (rst_i)
    begin
      cs_s3_reg <= 1'b1;
      tgl_seen_reg <= 1'b0;
    end
    else
    begin
      cs_s3_reg <= cs_s2_reg;
      if (cs_s2_reg & ~cs_s3_reg)
        tgl_seen_reg <= tgl_s2_reg;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wc_state_reg <= spi_eeprom_pkg::WC_IDLE;
      wc_cnt_reg <= '0;
      latch_reg <= 1'b0;
      arm_reg <= 1'b0;
      pl_reg <= spi_eeprom_pkg::PL_NONE;
      pend_st_reg <= 1'b0;
      pend_arm_reg <= 1'b0;
      pend_pl_reg <= 2'h0;
    end
    else
    begin
      wc_state_reg <= wc_state_next;
      wc_cnt_reg <= wc_cnt_next;
      latch_reg <= latch_next;
      if (go_write_status_cmd)
      begin
        pend_st_reg <= 1'b1;
        pend_arm_reg <= data_reg[`ST_ARM];
        pend_pl_reg <= data_reg[`ST_PL_HI:`ST_PL_LO];
      end
      else if (wc_end)
        pend_st_reg <= 1'b0;
      if (wc_end && pend_st_reg)
      begin
        arm_reg <= pend_arm_reg;
        pl_reg <= pend_pl_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      stat_view_reg <= `ST_RESET;
      wr_go_reg <= 1'b0;
      wr_addr_reg <= 10'h000;
    end
    else
    begin
      stat_view_reg <= busy ? `ST_ALL_ONES : stat_word;
      wr_go_reg <= go_warr;
      if (go_warr)
        wr_addr_reg <= addr;
    end
  end

  assign status_o = stat_view_reg;
  assign array_wr_go_o = wr_go_reg;
  assign array_wr_addr_o = wr_addr_reg;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_busy_all_ones: assert property (
    busy |=> status_o == `ST_ALL_ONES)
    else $error("status not all ones during write");
  chk_idle_dc_zero: assert property (
    !busy [*2] |-> status_o[`ST_DC_HI:`ST_DC_LO] == `DC_ZERO)
    else $error("spare status bits nonzero when idle");
  chk_cycle_needs_latch: assert property (
    !busy ##1 busy |-> $past(latch_reg))
    else $error("write cycle started with latch clear");
  chk_guard_locks: assert property (
    $rose(pend_st_reg) |-> !$past(hw_prot))
    else $error("status write taken under guard");
  chk_arm_no_drop: assert property (
    $rose(pend_st_reg) && !pend_arm_reg |-> !$past(arm_reg && !wp_s2_reg))
    else $error("arm bit cleared while guard pin low");
  chk_array_range: assert property (
    array_wr_go_o |-> $past(latch_reg) && !$past(prot_hit))
    else $error("array write into protected range");
  chk_busy_ignores: assert property (
    busy && !wc_end && frame_end |=> $stable(latch_reg))
    else $error("instruction taken while busy");
  chk_latch_clears: assert property (
    wc_end |=> !latch_reg && !busy)
    else $error("latch left set after write");
  chk_fields_held: assert property (
    busy && !wc_end |=> $stable(arm_reg) && $stable(pl_reg))
    else $error("status fields changed mid write");
  chk_ragged_frame: assert property (
    frame_end && !aligned && !busy |=> !busy && $stable(latch_reg))
    else $error("ragged frame changed state");
  chk_idle_released: assert property (
    cs_s2_reg |-> so_oe_n_o)
    else $error("output driven while deselected");

  cov_status_write: cover property (go_write_status_cmd);
  cov_array_write: cover property (go_warr);
  cov_status_read: cover property (take && is_rd);
  cov_busy_frame: cover property (busy && frame_end);
endmodule

/* File: bench/spi_master_model.sv */
// behavioural spi master that drives the eeprom link
`timescale 1ns/1ns
module spi_master_model (
  input wire logic so_i,
  input wire logic so_oe_n_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // sck stands still at the mode level outside frames
  task automatic xfer(input int nb, input logic [31:0] tx, input int ha,
    input logic m3, output logic [7:0] rx, output logic hz);
    hz = 1'b0;
    rx = 8'h00;
    sck_o = m3;
    #83 cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      #80 sck_o = 1'b0;
      if (i == ha)
      begin
        #40 hold_n_o = 1'b0;
        si_o = ~tx[31 - i];
        repeat (4) #40 sck_o = ~sck_o;
        hz = so_oe_n_i;
        #40 hold_n_o = 1'b1;
      end
      si_o = tx[31 - i];
      #80 sck_o = 1'b1;
      rx = {rx[6:0], so_i};
    end
    #80 sck_o = m3;
    // released data line toggles so a stale level cannot pass
    si_o = ~si_o;
    #80 cs_n_o = 1'b1;
    #160;
  endtask
endmodule

/* File: bench/spi_eeprom_status_protect_tb.sv */
// self-checking bench for the eeprom status and protection block
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end
module spi_eeprom_status_protect_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  wire sck, cs_n, si, hold_n, so, so_oe_n, go;
  wire [7:0] st;
  wire [9:0] wa;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int gos = 0;
  logic [9:0] wq[$];
  logic [9:0] wexp;
  integer seed = 32'h60c6;
  logic latch = 1'b0;
  logic arm = 1'b0;
  logic [1:0] pl = 2'b00;
  logic m3 = 1'b0;
  logic hz;
  logic [7:0] v;
  // long enough that status reads fit inside one write cycle
  spi_eeprom_status_protect #(.WRITE_CYCLES(1000)) i_dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
    .so_oe_n_o(so_oe_n), .status_o(st), .array_wr_go_o(go),
    .array_wr_addr_o(wa));
  spi_master_model i_master (.so_i(so), .so_oe_n_i(so_oe_n),
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (go === 1'b1)
    begin
      gos++;
      if (wq.size() > 0)
        wexp = wq.pop_front();
      else
        wexp = ~wa;
      `CHK(wa, wexp)
    end
    if (cyc == 90000)
    begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [7:0] exp_st();
    return {arm, 3'b000, pl, latch, 1'b0};
  endfunction
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic idle();
    while (st === 8'hff && cyc < 90000)
      @(posedge sys_clk);
  endtask
  task automatic xf(input int nb, input logic [31:0] tx, input int ha);
    m3 = 1'($random(seed));
    i_master.xfer(nb, tx | ($random(seed) & 32'h08000000), ha, m3, v,
      hz);
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic wen(input logic on);
    xf(8, on ? 32'h06000000 : 32'h04000000, -1);
    latch = on;
    `CHK(st, exp_st())
  endtask
  task automatic rdst(input int ha);
    xf(16, 32'h05000000, ha);
    `CHK(v, exp_st())
  endtask
  task automatic wrst(input logic [7:0] d);
    logic ok;
    ok = latch && !(!wp_n && arm);
    xf(16, {8'h01, d, 16'h0000}, -1);
    latch = 1'b0;
    if (ok)
    begin
      `CHK(st, 8'hff)
      xf(16, {8'h01, ~d, 16'h0000}, -1);
      xf(16, 32'h05000000, -1);
      `CHK(v, 8'hff)
      idle();
      {arm, pl} = {d[7], d[3:2]};
      xf(16, 32'h05000000, -1);
      rdst(-1);
    end
    `CHK(st, exp_st())
  endtask
  task automatic arrw(input logic [9:0] a);
    int g;
    logic ok;
    g = gos;
    ok = latch && !(pl == 2'b11 || (pl == 2'b10 && a[9]) ||
      (pl == 2'b01 && a[9:8] == 2'b11));
    if (ok)
      wq.push_back(a);
    xf(32, {8'h02, 6'h15, a, 8'($random(seed))}, -1);
    latch = 1'b0;
    `CHK(gos != g, ok)
    if (ok)
    begin
      `CHK(wa, a)
      repeat (1000) @(posedge sys_clk);
    end
    `CHK(st, exp_st())
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK(st, 8'h00)
    rdst(-1);
    `CHK(so_oe_n, 1'b1)
    wrst(8'h8c);
    note("no_latch");
    repeat (4)
    begin
      wen(1'b1);
      wen(1'b0);
      wen(1'b1);
      wrst(8'($random(seed)));
    end
    note("status");
    wen(1'b1);
    wrst(8'h84);
    @(negedge sys_clk) wp_n = 1'b0;
    wen(1'b1);
    wrst(8'h00);
    wen(1'b1);
    arrw(10'h100);
    wen(1'b1);
    arrw(10'h300);
    @(negedge sys_clk) wp_n = 1'b1;
    wen(1'b1);
    wrst(8'h00);
    note("guard");
    for (int k = 0; k < 12; k++)
    begin
      @(negedge sys_clk) wp_n = 1'($random(seed));
      wen(1'b1);
      wrst(8'($random(seed)));
      if (k % 3 != 0)
        wen(1'b1);
      arrw(10'($random(seed)));
    end
    @(negedge sys_clk) wp_n = 1'b1;
    note("protect");
    xf(7, 32'h06000000, -1);
    `CHK(st, exp_st())
    wen(1'b1);
    xf(12, 32'h01800000, -1);
    idle();
    `CHK(st, exp_st())
    rdst(10);
    `CHK(hz, 1'b1)
    note("frame");
    `CHK(wq.size(), 0)
    complete_run();
  end
endmodule
